// ---- dv/acz_regs_assertions.sv ----
// Checker: handshake and register output assertions for the channel-zero bank
`timescale 1ns/1ps
`default_nettype none
module acz_regs_assertions
  import acz_pkg::*;
(
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset, active low
  input wire logic s_axi_awready, // Write address ready
  input wire logic s_axi_wready, // Write data ready
  input wire logic [1:0] s_axi_bresp, // Write response
  input wire logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic s_axi_arvalid, // Read address valid
  input wire logic s_axi_arready, // Read address ready
  input wire logic [31:0] s_axi_rdata, // Read data
  input wire logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic global_dc_filter_setting, // Global filter
  input wire logic signed [ACZ_PHASE_W-1:0] chan_zero_phase_delay, // Phase
  input wire logic chan_zero_dc_filter_on, // Filter on
  input wire logic [ACZ_OFS_W-1:0] chan_zero_offset, // Offset
  input wire logic route_pins, // Pins routed
  input wire logic route_short, // Inputs shorted
  input wire logic route_test_pos, // Positive test
  input wire logic route_test_neg // Negative test
);
  // One clock domain, so one default clock and disable
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Reset checks run with the disable switched off
  a_reset_phase_route: assert property (disable iff (1'b0) !aresetn |=> route_pins && chan_zero_phase_delay == 0)
    else $error("phase or route not at reset value");
  a_reset_offset_zero: assert property (disable iff (1'b0) !aresetn |=> chan_zero_offset == 24'h000000)
    else $error("offset not zero after reset");
  a_filter_needs_global: assert property (!global_dc_filter_setting |-> !chan_zero_dc_filter_on)
    else $error("filter on without global setting");
  a_route_one_hot: assert property ($onehot({route_pins, route_short, route_test_pos, route_test_neg}))
    else $error("route controls not one-hot");
  // Stored values move only at the edge that raises the write response
  a_offset_on_write: assert property (!$rose(s_axi_bvalid) |-> $stable(chan_zero_offset))
    else $error("offset changed without a write");
  a_phase_on_write: assert property (!$rose(s_axi_bvalid) |-> $stable(chan_zero_phase_delay))
    else $error("phase changed without a write");
  a_rdata_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  a_read_one_cycle: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_no_write_in_resp: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
endmodule
bind acz_regs acz_regs_assertions u_chk (.aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .global_dc_filter_setting, .chan_zero_phase_delay, .chan_zero_dc_filter_on, .chan_zero_offset,
  .route_pins, .route_short, .route_test_pos, .route_test_neg);
`default_nettype wire

// ---- dv/acz_regs_tb.sv ----
// Testbench: register bank driven through AXI4-Lite read and write tasks
`timescale 1ns/1ps
`default_nettype none
module acz_regs_tb
  import acz_pkg::*;
;
  logic aclk = 1'b0, aresetn = 1'b0, global_dc_filter_setting = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [ACZ_ADDR_W-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic signed [ACZ_PHASE_W-1:0] chan_zero_phase_delay;
  logic chan_zero_dc_filter_on, route_pins, route_short, route_test_pos, route_test_neg;
  logic [ACZ_OFS_W-1:0] chan_zero_offset;
  logic [9:0] ph;
  int num_errors = 0, checks_done = 0, i;

  acz_regs u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .global_dc_filter_setting,
    .chan_zero_phase_delay, .chan_zero_dc_filter_on, .chan_zero_offset, .route_pins, .route_short,
    .route_test_pos, .route_test_neg);

  // 200 MHz clock
  always #2.5 aclk = ~aclk;

  task tally_and_finish;
    $display("checks_done %0d num_errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Handshakes are judged at the falling edge, so settled values decide what the next rising edge takes
  task wchk(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    bit aw_hs, w_hs, b_hs;
    logic [1:0] r;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    b_hs = 1'b0;
    // No cycle count is assumed; only the watchdog ends a hung wait
    while (!b_hs) begin
      @(negedge aclk);
      aw_hs = s_axi_awvalid && s_axi_awready;
      w_hs = s_axi_wvalid && s_axi_wready;
      b_hs = s_axi_bvalid && s_axi_bready;
      r = s_axi_bresp;
      @(posedge aclk);
      if (aw_hs) s_axi_awvalid <= 1'b0;
      if (w_hs) s_axi_wvalid <= 1'b0;
      if (b_hs) s_axi_bready <= 1'b0;
    end
    chk("bresp", {30'h0, er}, {30'h0, r});
  endtask

  task rchk(input string nm, input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    bit ar_hs, r_hs;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    r_hs = 1'b0;
    while (!r_hs) begin
      @(negedge aclk);
      ar_hs = s_axi_arvalid && s_axi_arready;
      r_hs = s_axi_rvalid && s_axi_rready;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ar_hs) s_axi_arvalid <= 1'b0;
      if (r_hs) s_axi_rready <= 1'b0;
    end
    chk(nm, ed, d);
    chk("rresp", {30'h0, er}, {30'h0, r});
  endtask

  // Main sequence
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rchk("cfg", ACZ_ADDR_CFG, 32'h0, ACZ_RESP_OKAY);
    rchk("upper", ACZ_ADDR_OFS_UPPER, 32'h0, ACZ_RESP_OKAY);
    rchk("lower", ACZ_ADDR_OFS_LOWER, 32'h0, ACZ_RESP_OKAY);
    @(negedge aclk);
    chk("route", 32'h8, {28'h0, route_pins, route_short, route_test_pos, route_test_neg});
    wchk(ACZ_ADDR_OFS_UPPER, 32'hffff_a5c3, 4'hf, ACZ_RESP_OKAY);
    rchk("upper", ACZ_ADDR_OFS_UPPER, 32'h0000_a5c3, ACZ_RESP_OKAY);
    wchk(ACZ_ADDR_OFS_LOWER, 32'h1234_5678, 4'hf, ACZ_RESP_OKAY);
    rchk("lower", ACZ_ADDR_OFS_LOWER, 32'h0000_5600, ACZ_RESP_OKAY);
    wchk(ACZ_ADDR_OFS_UPPER, 32'h0000_1122, 4'h1, ACZ_RESP_OKAY);
    // Unmapped place: write ignored, error answer
    wchk(8'h30, 32'hffff_ffff, 4'hf, ACZ_RESP_SLVERR);
    rchk("unmapped", 8'h30, 32'h0, ACZ_RESP_SLVERR);
    @(negedge aclk);
    chk("offset", 32'h00a5_2256, {8'h0, chan_zero_offset});
    // Every input code and filter pairing, negative phases, reserved bits written as ones
    for (i = 0; i < 8; i++) begin
      ph = 10'h200 + 10'(i);
      @(posedge aclk);
      global_dc_filter_setting <= i[0];
      wchk(ACZ_ADDR_CFG, {16'h5a5a, ph, 3'b111, i[2], i[1:0]}, 4'h3, ACZ_RESP_OKAY);
      rchk("cfg", ACZ_ADDR_CFG, {16'h0, ph, 3'b000, i[2], i[1:0]}, ACZ_RESP_OKAY);
      @(negedge aclk);
      chk("phase", {22'h0, ph}, {22'h0, chan_zero_phase_delay});
      chk("sign", 32'h1, {31'h0, chan_zero_phase_delay < 0});
      chk("filter", {31'h0, i[0] & ~i[2]}, {31'h0, chan_zero_dc_filter_on});
      chk("route", 32'h8 >> i[1:0], {28'h0, route_pins, route_short, route_test_pos, route_test_neg});
    end
    // Reset in mid-run clears all three registers
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rchk("upper", ACZ_ADDR_OFS_UPPER, 32'h0, ACZ_RESP_OKAY);
    rchk("lower", ACZ_ADDR_OFS_LOWER, 32'h0, ACZ_RESP_OKAY);
    rchk("cfg", ACZ_ADDR_CFG, 32'h0, ACZ_RESP_OKAY);
    // Global filter is still on, so a cleared local bit shows the filter enabled again
    @(negedge aclk);
    chk("route", 32'h8, {28'h0, route_pins, route_short, route_test_pos, route_test_neg});
    chk("filter", 32'h1, {31'h0, chan_zero_dc_filter_on});
    tally_and_finish;
  end

  // Watchdog, far beyond the hundred-odd cycles the tests need
  initial begin
    #20000;
    num_errors++;
    tally_and_finish;
  end
endmodule
`default_nettype wire

// ---- hw/acz_input_route.sv ----
// Input router: decodes the input select into one-hot analog switch controls
`timescale 1ns/1ps
`default_nettype none
module acz_input_route
  import acz_pkg::*;
(
  input wire logic aclk, // System clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire acz_sel_t sel, // Input select code
  output logic route_pins, // Connect positive and negative input pins
  output logic route_short, // Short converter inputs
  output logic route_test_pos, // Positive DC test signal
  output logic route_test_neg // Negative DC test signal
);

  logic [3:0] sw_d;
  logic [3:0] sw_q;

  // One switch at a time; registered so switch controls never glitch
  always_comb begin
    sw_d = 4'h0;
    if (aresetn) begin
      unique case (sel)
        ACZ_SEL_PINS: sw_d = 4'h1;
        ACZ_SEL_SHORT: sw_d = 4'h2;
        ACZ_SEL_TEST_POS: sw_d = 4'h4;
        ACZ_SEL_TEST_NEG: sw_d = 4'h8;
      endcase
    end else begin
      sw_d = 4'h1;
    end
  end

  // Switch state register
  always_ff @(posedge aclk) begin
    sw_q <= sw_d;
  end

  assign route_pins = sw_q[0];
  assign route_short = sw_q[1];
  assign route_test_pos = sw_q[2];
  assign route_test_neg = sw_q[3];

endmodule
`default_nettype wire

// ---- hw/acz_pkg.sv ----
// Package: register map, field layout and reset values of the channel-zero register bank
package acz_pkg;

  // Register indices as printed; byte address is four times the index
  localparam logic [7:0] ACZ_IDX_CFG = 8'h09;
  localparam logic [7:0] ACZ_IDX_OFS_UPPER = 8'h0a;
  localparam logic [7:0] ACZ_IDX_OFS_LOWER = 8'h0b;

  // Byte addresses on the bus
  localparam int ACZ_ADDR_W = 8;
  localparam logic [ACZ_ADDR_W-1:0] ACZ_ADDR_CFG = 8'h24;
  localparam logic [ACZ_ADDR_W-1:0] ACZ_ADDR_OFS_UPPER = 8'h28;
  localparam logic [ACZ_ADDR_W-1:0] ACZ_ADDR_OFS_LOWER = 8'h2c;

  // Configuration word field layout
  localparam int ACZ_PHASE_LSB = 6;
  localparam int ACZ_PHASE_W = 10;
  localparam int ACZ_DCOFF_BIT = 2;
  localparam int ACZ_MUX_LSB = 0;
  localparam int ACZ_MUX_W = 2;

  // Offset calibration layout
  localparam int ACZ_OFS_W = 24;
  localparam int ACZ_OFS_LOWER_LSB = 8;

  // Reset values
  localparam logic [ACZ_PHASE_W-1:0] ACZ_PHASE_RST = 10'h000;
  localparam logic ACZ_DCOFF_RST = 1'b0;
  localparam logic [15:0] ACZ_OFS_UPPER_RST = 16'h0000;
  localparam logic [7:0] ACZ_OFS_LOWER_RST = 8'h00;

  // Input selection codes
  typedef enum logic [1:0] {
    ACZ_SEL_PINS = 2'h0,
    ACZ_SEL_SHORT = 2'h1,
    ACZ_SEL_TEST_POS = 2'h2,
    ACZ_SEL_TEST_NEG = 2'h3
  } acz_sel_t;

  // AXI response codes
  localparam logic [1:0] ACZ_RESP_OKAY = 2'h0;
  localparam logic [1:0] ACZ_RESP_SLVERR = 2'h2;

endpackage

// ---- hw/acz_regs.sv ----
// Channel-zero configuration and offset calibration registers behind an AXI4-Lite slave
//
// Behaviour
// - Phase bits 15:6 are a signed delay in modulator clocks, reset zero.
// - Bit 2 clear follows global DC filter; set turns channel-zero filter off.
// - Input select 00 routes channel pins (reset); 01 shorts converter inputs.
// - Input select 10 applies positive test signal; 11 negative test signal.
// - Upper offset register holds offset bits 23:8, all read/write.
// - Lower offset bits 15:8 hold offset 7:0; bits 7:0 read zero.
// - Upper offset register at index 0xA resets to zero.
// - Lower offset register at index 0xB resets to zero.
`timescale 1ns/1ps
`default_nettype none
module acz_regs
  import acz_pkg::*;
(
  input wire logic aclk, // System clock, 200 MHz
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic [ACZ_ADDR_W-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [ACZ_ADDR_W-1:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic global_dc_filter_setting, // Global DC filter enable
  output logic signed [ACZ_PHASE_W-1:0] chan_zero_phase_delay, // Signed phase delay
  output logic chan_zero_dc_filter_on, // Effective DC filter enable
  output logic [ACZ_OFS_W-1:0] chan_zero_offset, // 24-bit offset calibration value
  output logic route_pins, // Route channel input pins
  output logic route_short, // Short converter inputs
  output logic route_test_pos, // Positive DC test signal
  output logic route_test_neg // Negative DC test signal
);

  // Register state
  logic [ACZ_PHASE_W-1:0] phase_q, phase_d;
  logic dcoff_q, dcoff_d;
  acz_sel_t sel_q, sel_d;
  logic [15:0] ofs_upper_q, ofs_upper_d;
  logic [7:0] ofs_lower_q, ofs_lower_d;

  // Write channel state
  logic aw_held_q, aw_held_d;
  logic [ACZ_ADDR_W-1:0] awaddr_q, awaddr_d;
  logic w_held_q, w_held_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;

  // Read channel state
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;

  // Combined views
  logic [15:0] cfg_word;
  logic [15:0] lower_word;
  logic do_write;
  logic [ACZ_ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;

  assign cfg_word = {phase_q, 3'h0, dcoff_q, sel_q};
  assign lower_word = {ofs_lower_q, 8'h00};

  // Address and data are taken in either order; a held item blocks a second one
  assign s_axi_awready = aresetn && !aw_held_q && !bvalid_q;
  assign s_axi_wready = aresetn && !w_held_q && !bvalid_q;
  assign s_axi_arready = aresetn && !rvalid_q;

  // Merge freshly taken items with held ones
  always_comb begin
    wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
    wr_data = w_held_q ? wdata_q : s_axi_wdata;
    wr_strb = w_held_q ? wstrb_q : s_axi_wstrb;
    do_write = (aw_held_q || (s_axi_awvalid && s_axi_awready)) &&
               (w_held_q || (s_axi_wvalid && s_axi_wready));
  end

  // Write path: hold items until both halves arrived, then commit and respond
  always_comb begin
    aw_held_d = aw_held_q;
    awaddr_d = awaddr_q;
    w_held_d = w_held_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    phase_d = phase_q;
    dcoff_d = dcoff_q;
    sel_d = sel_q;
    ofs_upper_d = ofs_upper_q;
    ofs_lower_d = ofs_lower_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (do_write) begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = ACZ_RESP_OKAY;
      unique case (wr_addr)
        ACZ_ADDR_CFG: begin
          if (wr_strb[1]) begin
            phase_d[ACZ_PHASE_W-1:2] = wr_data[15:8];
          end
          if (wr_strb[0]) begin
            phase_d[1:0] = wr_data[7:6];
            dcoff_d = wr_data[ACZ_DCOFF_BIT];
            sel_d = acz_sel_t'(wr_data[ACZ_MUX_LSB +: ACZ_MUX_W]);
          end
        end
        ACZ_ADDR_OFS_UPPER: begin
          if (wr_strb[0]) begin
            ofs_upper_d[7:0] = wr_data[7:0];
          end
          if (wr_strb[1]) begin
            ofs_upper_d[15:8] = wr_data[15:8];
          end
        end
        ACZ_ADDR_OFS_LOWER: begin
          // only the high byte is writable
          if (wr_strb[1]) begin
            ofs_lower_d = wr_data[15:8];
          end
        end
        default: bresp_d = ACZ_RESP_SLVERR;
      endcase
    end
  end

  // Read path: one-cycle answer from registered data
  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d = ACZ_RESP_OKAY;
      unique case (s_axi_araddr)
        ACZ_ADDR_CFG: rdata_d = {16'h0000, cfg_word};
        ACZ_ADDR_OFS_UPPER: rdata_d = {16'h0000, ofs_upper_q};
        ACZ_ADDR_OFS_LOWER: rdata_d = {16'h0000, lower_word};
        default: begin
          rdata_d = 32'h0000_0000;
          rresp_d = ACZ_RESP_SLVERR;
        end
      endcase
    end
  end

  // State registers; synchronous reset to documented values
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_q <= ACZ_PHASE_RST;
      dcoff_q <= ACZ_DCOFF_RST;
      sel_q <= ACZ_SEL_PINS;
      ofs_upper_q <= ACZ_OFS_UPPER_RST;
      ofs_lower_q <= ACZ_OFS_LOWER_RST;
      aw_held_q <= 1'b0;
      awaddr_q <= '0;
      w_held_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= ACZ_RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= ACZ_RESP_OKAY;
    end else begin
      phase_q <= phase_d;
      dcoff_q <= dcoff_d;
      sel_q <= sel_d;
      ofs_upper_q <= ofs_upper_d;
      ofs_lower_q <= ofs_lower_d;
      aw_held_q <= aw_held_d;
      awaddr_q <= awaddr_d;
      w_held_q <= w_held_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // signed delay to the phase shifter
  assign chan_zero_phase_delay = $signed(phase_q);
  // local disable overrides the global setting
  assign chan_zero_dc_filter_on = global_dc_filter_setting && !dcoff_q;
  assign chan_zero_offset = {ofs_upper_q, ofs_lower_q};

  // Switch decode kept in its own module so the analog side sees clean one-hot controls
  acz_input_route u_route (
    .aclk(aclk),
    .aresetn(aresetn),
    .sel(sel_q),
    .route_pins(route_pins),
    .route_short(route_short),
    .route_test_pos(route_test_pos),
    .route_test_neg(route_test_neg)
  );

endmodule
`default_nettype wire
